// File: core/status_indicator_controller.sv
// status indicator controller: power and busy lamps follow the adapter state
// assumes state inputs come from logic on core_clk; lamp outputs high = lit
//
// Function
// - Idle waiting for a host command shows power on, busy off.
// - Emulation running shows both lamps steadily on.
// - Flash writing shows both lamps steadily on.
// - Firmware update blinks power at 0.25 s, keeps busy on, then requests a restart.
// - Supply reference out of range keeps power on and blinks busy at 0.5 s.
// - Driver recognition failure blinks both lamps together at 0.5 s.
// - Command error blinks power at 0.5 s with busy off.
// - Target link error blinks both at 0.5 s with busy in antiphase.
// - Corrupt firmware blinks both lamps at 0.25 s.
// - Self-detected hardware failure turns both lamps off.
`default_nettype none
module status_indicator_controller
  import lamp_pkg::*;
#(
  parameter int unsigned FAST_CYC = FAST_HALF_CYC,
  parameter int unsigned SLOW_CYC = SLOW_HALF_CYC
) (
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  input  wire logic  emulating,
  input  wire logic  flash_writing,
  input  wire logic  fw_updating,
  input  wire logic  fw_update_done,
  input  wire logic  supply_fault,
  input  wire logic  driver_fail,
  input  wire logic  cmd_error,
  input  wire logic  link_error,
  input  wire logic  fw_corrupt,
  input  wire logic  hw_broken,
  output logic       power_lamp,
  output logic       busy_lamp,
  output logic       restart_req,
  output ind_state_t cur_state
);
  if (FAST_CYC < 2)
  begin : g_bad_fast
    $error("status_indicator_controller: FAST_CYC must be at least 2");
  end

  if (SLOW_CYC < 2)
  begin : g_bad_slow
    $error("status_indicator_controller: SLOW_CYC must be at least 2");
  end

  // ======================================================================
  // blink phase sources
  logic fast_ph;
  logic slow_ph;

  blink_prescaler #(.HALF_CYC(FAST_CYC)) u_fast (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .phase    (fast_ph)
  );

  blink_prescaler #(.HALF_CYC(SLOW_CYC)) u_slow (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .phase    (slow_ph)
  );

  // ======================================================================
  // state selection by fixed priority, errors first
  ind_state_t state_r;
  ind_state_t state_nxt;

  always_comb
  begin
    if (hw_broken)          state_nxt = ST_BROKEN;
    else if (fw_corrupt)    state_nxt = ST_FW_CORRUPT;
    else if (driver_fail)   state_nxt = ST_DRIVER_FAIL;
    else if (supply_fault)  state_nxt = ST_SUPPLY_FAULT;
    else if (link_error)    state_nxt = ST_LINK_ERROR;
    else if (cmd_error)     state_nxt = ST_CMD_ERROR;
    else if (fw_updating)   state_nxt = ST_FW_UPDATE;
    else if (flash_writing) state_nxt = ST_FLASH;
    else if (emulating)     state_nxt = ST_EMULATE;
    else                    state_nxt = ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ======================================================================
  // restart request while a firmware update completes
  logic restart_r;
  logic restart_nxt;

  always_comb
  begin
    restart_nxt = (state_r == ST_FW_UPDATE) && fw_update_done;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      restart_r <= 1'b0;
    end
    else
    begin
      restart_r <= restart_nxt;
    end
  end

  // ======================================================================
  // lamp patterns
  typedef enum logic [2:0] {
    LM_OFF,
    LM_ON,
    LM_FAST,
    LM_SLOW,
    LM_SLOW_INV
  } lamp_mode_t;

  // one decoder for both lamps, so blinking lamps share the phase sources
  function automatic logic lamp_level(
    input lamp_mode_t mode,
    input logic       fast,
    input logic       slow
  );
    unique case (mode)
      LM_OFF:      lamp_level = 1'b0;
      LM_ON:       lamp_level = 1'b1;
      LM_FAST:     lamp_level = fast;
      LM_SLOW:     lamp_level = slow;
      LM_SLOW_INV: lamp_level = ~slow;
      default:     lamp_level = 1'b0;
    endcase
  endfunction : lamp_level

  lamp_mode_t pwr_mode;
  lamp_mode_t busy_mode;
  logic       pwr_r;
  logic       pwr_nxt;
  logic       busy_r;
  logic       busy_nxt;

  always_comb
  begin
    unique case (state_r)
      ST_IDLE:
      begin
        pwr_mode  = LM_ON;
        busy_mode = LM_OFF;
      end
      ST_EMULATE:
      begin
        pwr_mode  = LM_ON;
        busy_mode = LM_ON;
      end
      ST_FLASH:
      begin
        pwr_mode  = LM_ON;
        busy_mode = LM_ON;
      end
      ST_FW_UPDATE:
      begin
        pwr_mode  = LM_FAST;
        busy_mode = LM_ON;
      end
      ST_SUPPLY_FAULT:
      begin
        pwr_mode  = LM_ON;
        busy_mode = LM_SLOW;
      end
      ST_DRIVER_FAIL:
      begin
        pwr_mode  = LM_SLOW;
        busy_mode = LM_SLOW;
      end
      ST_CMD_ERROR:
      begin
        pwr_mode  = LM_SLOW;
        busy_mode = LM_OFF;
      end
      ST_LINK_ERROR:
      begin
        pwr_mode  = LM_SLOW;
        busy_mode = LM_SLOW_INV;
      end
      ST_FW_CORRUPT:
      begin
        pwr_mode  = LM_FAST;
        busy_mode = LM_FAST;
      end
      ST_BROKEN:
      begin
        pwr_mode  = LM_OFF;
        busy_mode = LM_OFF;
      end
      default:
      begin
        pwr_mode  = LM_OFF;
        busy_mode = LM_OFF;
      end
    endcase
    pwr_nxt  = lamp_level(pwr_mode, fast_ph, slow_ph);
    busy_nxt = lamp_level(busy_mode, fast_ph, slow_ph);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_r  <= 1'b1;
      busy_r <= 1'b0;
    end
    else
    begin
      pwr_r  <= pwr_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign power_lamp  = pwr_r;
  assign busy_lamp   = busy_r;
  assign restart_req = restart_r;
  assign cur_state   = state_r;
endmodule : status_indicator_controller
`default_nettype wire

// File: core/lamp_pkg.sv
// constants and types for the status indicator controller
// assumes a single 40 MHz core clock
`default_nettype none
package lamp_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned FAST_HALF_MS    = 250;
  localparam int unsigned SLOW_HALF_MS    = 500;
  localparam int unsigned FAST_HALF_CYC   = CLK_HZ / 1000 * FAST_HALF_MS;
  localparam int unsigned SLOW_HALF_CYC   = CLK_HZ / 1000 * SLOW_HALF_MS;
  localparam int unsigned RESTART_PULSE   = 1;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_EMULATE,
    ST_FLASH,
    ST_FW_UPDATE,
    ST_SUPPLY_FAULT,
    ST_DRIVER_FAIL,
    ST_CMD_ERROR,
    ST_LINK_ERROR,
    ST_FW_CORRUPT,
    ST_BROKEN
  } ind_state_t;
endpackage : lamp_pkg
`default_nettype wire

// File: core/blink_prescaler.sv
// free-running prescaler giving a toggling phase at a programmable half period
// assumes the core clock and reset of the enclosing controller
`default_nettype none
module blink_prescaler #(
  parameter int unsigned HALF_CYC = 10_000_000
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      phase
);
  localparam int unsigned CW = $clog2(HALF_CYC);

  if (HALF_CYC < 2)
  begin : g_bad_half
    $error("blink_prescaler: HALF_CYC must be at least 2");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          phase_r;
  logic          phase_nxt;

  always_comb
  begin
    cnt_nxt   = cnt_r + CW'(1);
    phase_nxt = phase_r;
    if (cnt_r == CW'(HALF_CYC - 1))
    begin
      cnt_nxt   = '0;
      phase_nxt = ~phase_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r   <= '0;
      phase_r <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign phase = phase_r;
endmodule : blink_prescaler
`default_nettype wire

// File: tb/lamp_asserts.sv
// checker for the status indicator controller
// assumes a bind from the bench top
`default_nettype none
module lamp_asserts
  import lamp_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       hw_broken,
  input wire logic       fw_update_done,
  input wire logic       power_lamp,
  input wire logic       busy_lamp,
  input wire logic       restart_req,
  input wire ind_state_t cur_state
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence upd_done_s;
    cur_state == ST_FW_UPDATE && fw_update_done;
  endsequence
  brk_state_a: assert property (hw_broken |=> cur_state == ST_BROKEN)
    else $error("bad pick");
  brk_lamps_a: assert property (cur_state == ST_BROKEN |=> !power_lamp && !busy_lamp)
    else $error("bad off");
  idle_lamps_a: assert property (cur_state == ST_IDLE |=> power_lamp && !busy_lamp)
    else $error("bad idle");
  emu_lamps_a: assert property (cur_state == ST_EMULATE |=> power_lamp && busy_lamp)
    else $error("bad emu");
  flash_lamps_a: assert property (cur_state == ST_FLASH |=> power_lamp && busy_lamp)
    else $error("bad flash");
  cmd_busy_a: assert property (cur_state == ST_CMD_ERROR |=> !busy_lamp)
    else $error("bad cmd");
  link_anti_a: assert property (cur_state == ST_LINK_ERROR |=> power_lamp != busy_lamp)
    else $error("bad link");
  corrupt_same_a: assert property (cur_state == ST_FW_CORRUPT |=> power_lamp == busy_lamp)
    else $error("bad sync");
  restart_req_a: assert property (upd_done_s |=> restart_req)
    else $error("no restart");
  restart_only_a: assert property (!(cur_state == ST_FW_UPDATE && fw_update_done)
    |=> !restart_req)
    else $error("stray restart");
  upd_busy_a: assert property (cur_state == ST_FW_UPDATE |=> busy_lamp)
    else $error("bad update");
  supply_pwr_a: assert property (cur_state == ST_SUPPLY_FAULT |=> power_lamp)
    else $error("bad supply");
  drv_same_a: assert property (cur_state == ST_DRIVER_FAIL |=> power_lamp == busy_lamp)
    else $error("bad driver");
endmodule : lamp_asserts
`default_nettype wire

// File: tb/status_indicator_controller_tb.sv
// bench for the status indicator controller
// assumes the design and lamp_asserts compiled first
`default_nettype none
`define CHK(a, b) num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t mismatch", $time); end
module status_indicator_controller_tb
  import lamp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        fw_done = 0;
  logic [8:0]  s = '0;
  logic [11:0] q[$];
  int          bad_count = 0;
  int          num_checks = 0;
  event        meas;
  wire         pl;
  wire         bl;
  wire         rr;
  ind_state_t  cs;
  // state and {power toggles, busy toggles, steady levels} per test
  logic [11:0] tbl[10] = '{12'h002, 12'h103, 12'h203, 12'h381, 12'h640,
                           12'h748, 12'h40a, 12'h548, 12'h890, 12'h900};
  status_indicator_controller #(.FAST_CYC(4), .SLOW_CYC(8)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .emulating(s[0]), .flash_writing(s[1]),
    .fw_updating(s[2]), .fw_update_done(fw_done), .cmd_error(s[3]),
    .link_error(s[4]), .supply_fault(s[5]), .driver_fail(s[6]),
    .fw_corrupt(s[7]), .hw_broken(s[8]), .power_lamp(pl), .busy_lamp(bl),
    .restart_req(rr), .cur_state(cs));
  // =====
  // stimulus
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) fw_done <= 1'($urandom);
  initial
  begin
    void'($urandom(32'hb3b5));
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    for (int i = 0; i < 10; i++)
    begin
      @(posedge core_clk);
      // winner bit set, random lower ones
      s <= i ? (9'($urandom) & ((9'h1 << (i - 1)) - 9'h1)) | (9'h1 << (i - 1)) : '0;
      repeat (3) @(posedge core_clk);
      q.push_back(tbl[i]);
      ->meas;
      repeat (18) @(posedge core_clk);
    end
    close_out();
  end
  always
  begin
    logic [7:0] m;
    logic       pp;
    logic       bb;
    logic       fd;
    logic       rbad;
    @(meas);
    m = '0;
    rbad = 1'b0;
    @(negedge core_clk);
    fd = fw_done;
    for (int k = 0; k < 16; k++)
    begin
      pp = pl;
      bb = bl;
      @(negedge core_clk);
      m[7:5] += 3'(pp != pl);
      m[4:2] += 3'(bb != bl);
      rbad |= rr !== (fd && q[0][11:8] == ST_FW_UPDATE);
      fd = fw_done;
    end
    m[1:0] = {m[7:5] == 0 && pl, m[4:2] == 0 && bl};
    `CHK(rbad, 1'b0)
    `CHK({cs, m}, q.pop_front())
    $display("test done at %0t", $time);
  end
  initial
  begin
    #50us;
    bad_count++;
    close_out();
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
endmodule : status_indicator_controller_tb
bind status_indicator_controller lamp_asserts chk (.core_clk, .rst_n, .hw_broken,
  .fw_update_done, .power_lamp, .busy_lamp, .restart_req, .cur_state);
`default_nettype wire
